// file: rtl/monitor_command.sv
// Serial monitor command interpreter and security gate.
// Assumes the CPU core offers a simple memory port answering in one cycle
// and accepts entry and run requests as one-cycle pulses.
`timescale 1ns/1ps
module monitor_command #(
	parameter int unsigned BAUD = monitor_pkg::BAUD_DEFAULT,
	parameter logic [15:0] FLASH_BASE = monitor_pkg::FLASH_BASE_DEFAULT
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Serial data pin, split into three signals
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe,
	// Entry-select pin
	input wire logic entry_select_pin,
	// CPU memory port
	output logic mem_rd,
	output logic [15:0] mem_addr,
	input wire logic [7:0] mem_rdata,
	// CPU register view
	input wire logic [15:0] stack_pointer,
	input wire logic [15:0] fetch_addr,
	input wire logic fetch_valid,
	// CPU control requests
	output logic software_interrupt,
	output logic push_high_index,
	output logic pop_high_index,
	output logic return_from_interrupt,
	output logic illegal_reset,
	// Status
	output logic unlocked,
	output logic monitor_active,
	output logic [7:0] read_data
);
	import monitor_pkg::*;

	localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
	localparam int unsigned CNT_W = $clog2(BIT_CYC * CANCEL_BITS + 1);

	// Elaboration check: a bit must span a few clocks for centre sampling
	if (BAUD == 0 || BIT_CYC < 4) begin : g_baud_check
		$error("BAUD too high for the system clock");
	end

	typedef enum logic [9:0] {
		ST_ENTRY = 10'b0000000001,
		ST_SEC_RX = 10'b0000000010,
		ST_BREAK = 10'b0000000100,
		ST_CMD_RX = 10'b0000001000,
		ST_FETCH = 10'b0000010000,
		ST_TX_WAIT = 10'b0000100000,
		ST_TX = 10'b0001000000,
		ST_CANCEL = 10'b0010000000,
		ST_RUN = 10'b0100000000,
		ST_USER = 10'b1000000000
	} state_e;

	state_e state;
	// Two-stage pin synchroniser
	logic rx_meta;
	logic rx_sync;
	// Two-stage entry-select synchroniser
	logic sel_meta;
	logic sel_sync;
	// Receiver
	logic rx_busy;
	logic [CNT_W-1:0] rx_cnt;
	logic [3:0] rx_bits;
	logic [8:0] rx_shift;
	logic rx_done;
	logic rx_break;
	logic [7:0] rx_byte;
	// Transmit queue: up to three bytes
	logic [7:0] tx_q [0:2];
	logic [1:0] tx_n;
	logic [1:0] tx_idx;
	logic tx_is_break;
	logic [CNT_W-1:0] tx_cnt;
	logic [3:0] tx_bits;
	logic [9:0] tx_shift;
	// Sequencing
	logic [3:0] sec_idx;
	logic sec_fail;
	// Cycles since reset release, for the entry-select hold time
	logic [4:0] entry_cnt;
	logic [15:0] last_addr;
	logic [1:0] fetch_step;
	logic [7:0] fetch_hi;
	logic [CNT_W-1:0] wait_cnt;
	logic mem_pending;

	// Truncate a bit-time multiple to the counter width
	function automatic logic [CNT_W-1:0] bit_times(input int unsigned n);
		return CNT_W'(BIT_CYC * n);
	endfunction

	// Address falls inside flash
	function automatic logic in_flash(input logic [15:0] a);
		return a >= FLASH_BASE;
	endfunction

	// Pin synchroniser; first stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			sel_meta <= 1'b1;
			sel_sync <= 1'b1;
		end else begin
			rx_meta <= serial_data_pin_in;
			rx_sync <= rx_meta;
			sel_meta <= entry_select_pin;
			sel_sync <= sel_meta;
		end
	end

	// NRZ receiver, centre-sampled; all-zero frame flags a break
	// NRZ receive framing
	always_ff @(posedge clk_sys) begin
		rx_done <= 1'b0;
		rx_break <= 1'b0;
		if (srst) begin
			rx_busy <= 1'b0;
			rx_cnt <= '0;
			rx_bits <= '0;
			rx_shift <= '0;
			rx_byte <= '0;
		end else if (serial_data_pin_oe) begin
			// Half duplex: ignore the line while we drive it
			rx_busy <= 1'b0;
		end else if (!rx_busy) begin
			if (!rx_sync) begin
				rx_busy <= 1'b1;
				rx_cnt <= CNT_W'(BIT_CYC / 2);
				rx_bits <= '0;
			end
		end else if (rx_cnt != '0) begin
			rx_cnt <= rx_cnt - 1'b1;
		end else begin
			// Reload one cycle short: the zero count is itself a cycle
			rx_cnt <= bit_times(1) - 1'b1;
			rx_shift <= {rx_sync, rx_shift[8:1]};
			rx_bits <= rx_bits + 1'b1;
			if (rx_bits == '0 && rx_sync) begin
				// False start (glitch or tail of a break): drop the frame
				rx_busy <= 1'b0;
			end else if (rx_bits == 4'(FRAME_BITS - 1)) begin
				rx_busy <= 1'b0;
				if (!rx_sync && rx_shift[8:1] == 8'h00) begin
					rx_break <= 1'b1;
				end else begin
					rx_done <= 1'b1;
					rx_byte <= rx_shift[8:1];
				end
			end
		end
	end

	// Main sequencer
	always_ff @(posedge clk_sys) begin
		software_interrupt <= 1'b0;
		push_high_index <= 1'b0;
		pop_high_index <= 1'b0;
		return_from_interrupt <= 1'b0;
		illegal_reset <= 1'b0;
		mem_rd <= 1'b0;
		if (srst) begin
			state <= ST_ENTRY;
			entry_cnt <= '0;
			unlocked <= 1'b0;
			sec_idx <= '0;
			sec_fail <= 1'b0;
			last_addr <= '0;
			fetch_step <= '0;
			fetch_hi <= '0;
			wait_cnt <= '0;
			mem_pending <= 1'b0;
			mem_addr <= '0;
			read_data <= '0;
			monitor_active <= 1'b0;
			tx_n <= '0;
			tx_is_break <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				tx_q[i] <= '0;
			end
		end else begin
			case (state)
				ST_ENTRY: begin
					if (entry_cnt != 5'(ENTRY_HOLD_XTAL - 1)) begin
						// Let the host's hold time run before looking at the pin
						entry_cnt <= entry_cnt + 1'b1;
					end else if (!sel_sync) begin
						software_interrupt <= 1'b1;
						push_high_index <= 1'b1;
						monitor_active <= 1'b1;
						state <= ST_SEC_RX;
					end else begin
						state <= ST_USER;
					end
				end
				ST_SEC_RX: begin
					if (mem_pending) begin
						mem_pending <= 1'b0;
						if (mem_rdata != rx_byte) begin
							sec_fail <= 1'b1;
						end
						tx_q[0] <= rx_byte;
						tx_n <= 2'd1;
						tx_is_break <= 1'b0;
						wait_cnt <= bit_times(TURN_BITS);
						state <= ST_TX_WAIT;
						sec_idx <= sec_idx + 1'b1;
						last_addr <= mem_addr;
					end else if (rx_done) begin
						mem_rd <= 1'b1;
						mem_addr <= SEC_FIRST + 16'(sec_idx);
						mem_pending <= 1'b1;
					end
				end
				ST_BREAK: begin
					unlocked <= !sec_fail;
					tx_is_break <= 1'b1;
					tx_n <= 2'd1;
					wait_cnt <= '0;
					state <= ST_TX_WAIT;
				end
				ST_CMD_RX: begin
					if (rx_done) begin
						tx_q[0] <= rx_byte;
						tx_is_break <= 1'b0;
						wait_cnt <= bit_times(TURN_BITS);
						if (rx_byte == OP_INDEXED_FETCH) begin
							fetch_step <= '0;
							state <= ST_FETCH;
						end else if (rx_byte == OP_STACK_QUERY) begin
							tx_q[1] <= 8'((stack_pointer + STK_HIGH_INDEX) >> 8);
							tx_q[2] <= 8'(stack_pointer + STK_HIGH_INDEX);
							tx_n <= 2'd3;
							state <= ST_TX_WAIT;
						end else if (rx_byte == OP_RUN) begin
							tx_n <= 2'd1;
							state <= ST_TX_WAIT;
						end else begin
							tx_n <= 2'd1;
							state <= ST_TX_WAIT;
						end
					end
				end
				ST_FETCH: begin
					if (fetch_step[0] == 1'b0) begin
						mem_rd <= 1'b1;
						mem_addr <= last_addr + 16'h0001;
						fetch_step <= fetch_step + 1'b1;
					end else begin
						read_data <= (!unlocked && in_flash(mem_addr)) ? LOCKED_DATA : mem_rdata;
						last_addr <= mem_addr;
						if (fetch_step == 2'd1) begin
							fetch_hi <= (!unlocked && in_flash(mem_addr)) ? LOCKED_DATA : mem_rdata;
							fetch_step <= 2'd2;
						end else begin
							tx_q[1] <= fetch_hi;
							tx_q[2] <= (!unlocked && in_flash(mem_addr)) ? LOCKED_DATA : mem_rdata;
							tx_n <= 2'd3;
							state <= ST_TX_WAIT;
						end
					end
				end
				ST_TX_WAIT: begin
					if (wait_cnt != '0) begin
						wait_cnt <= wait_cnt - 1'b1;
					end else begin
						state <= ST_TX;
					end
				end
				ST_TX: begin
					if (tx_bits == '0 && tx_cnt == '0 && !serial_data_pin_oe) begin
						if (tx_idx == tx_n) begin
							if (tx_is_break) begin
								tx_is_break <= 1'b0;
								state <= ST_CMD_RX;
							end else if (sec_idx < 4'(SEC_COUNT)) begin
								// Next security byte, match or not
								state <= ST_SEC_RX;
							end else if (sec_idx == 4'(SEC_COUNT)) begin
								sec_idx <= sec_idx + 1'b1;
								state <= ST_BREAK;
							end else begin
								wait_cnt <= bit_times(CANCEL_BITS);
								state <= ST_CANCEL;
							end
						end
					end
				end
				ST_CANCEL: begin
					if (rx_break) begin
						state <= ST_CMD_RX;
					end else if (wait_cnt != '0) begin
						wait_cnt <= wait_cnt - 1'b1;
					end else if (tx_q[0] == OP_RUN) begin
						state <= ST_RUN;
					end else begin
						state <= ST_CMD_RX;
					end
				end
				ST_RUN: begin
					pop_high_index <= 1'b1;
					return_from_interrupt <= 1'b1;
					monitor_active <= 1'b0;
					state <= ST_USER;
				end
				ST_USER: begin
					if (fetch_valid && in_flash(fetch_addr) && !unlocked) begin
						illegal_reset <= 1'b1;
					end
				end
				default: state <= ST_ENTRY;
			endcase
		end
	end

	// Transmitter: queued bytes, or ten zero bits as a break
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			serial_data_pin_out <= 1'b1;
			serial_data_pin_oe <= 1'b0;
			tx_cnt <= '0;
			tx_bits <= '0;
			tx_shift <= '1;
		end else if (state == ST_TX && tx_bits == '0 && tx_cnt == '0 && !serial_data_pin_oe
			&& tx_idx != tx_n) begin
			// Load next frame: start, eight data LSB first, stop
			tx_shift <= tx_is_break ? 10'h000 : {1'b1, tx_q[tx_idx], 1'b0};
			tx_bits <= 4'(BREAK_BITS);
			tx_cnt <= '0;
			serial_data_pin_oe <= 1'b1;
		end else if (serial_data_pin_oe) begin
			if (tx_cnt != '0) begin
				tx_cnt <= tx_cnt - 1'b1;
			end else if (tx_bits != '0) begin
				serial_data_pin_out <= tx_shift[0];
				tx_shift <= {1'b1, tx_shift[9:1]};
				tx_bits <= tx_bits - 1'b1;
				tx_cnt <= bit_times(1) - 1'b1;
			end else begin
				// Frame finished: release the pin high
				serial_data_pin_out <= 1'b1;
				serial_data_pin_oe <= 1'b0;
			end
		end
	end

	// Frame index advances when a frame is released
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tx_idx <= '0;
		end else if (state == ST_TX_WAIT) begin
			tx_idx <= '0;
		end else if (serial_data_pin_oe && tx_cnt == '0 && tx_bits == '0) begin
			tx_idx <= tx_idx + 1'b1;
		end
	end
endmodule

// file: rtl/monitor_pkg.sv
// Constants shared by the serial monitor command block.
// Assumes a single 40 MHz system clock and a one-pin half-duplex link.
package monitor_pkg;
	// System clock rate in Hz
	localparam int unsigned CLK_HZ = 40000000;
	// Default link rate in baud
	localparam int unsigned BAUD_DEFAULT = 9600;
	// Command opcodes
	localparam logic [7:0] OP_INDEXED_FETCH = 8'h1A;
	localparam logic [7:0] OP_STACK_QUERY = 8'h0C;
	localparam logic [7:0] OP_RUN = 8'h28;
	// Security range in flash
	localparam logic [15:0] SEC_FIRST = 16'hFFF6;
	localparam logic [15:0] SEC_LAST = 16'hFFFD;
	localparam int unsigned SEC_COUNT = 8;
	// Entry-select must stay low this many crystal cycles after reset
	localparam int unsigned ENTRY_HOLD_XTAL = 24;
	// Link framing, in bit times
	localparam int unsigned BREAK_BITS = 10;
	localparam int unsigned TURN_BITS = 2;
	localparam int unsigned CANCEL_BITS = 11;
	localparam int unsigned FRAME_BITS = 10;
	// Stack frame offsets above the stack pointer
	localparam logic [15:0] STK_HIGH_INDEX = 16'h0001;
	localparam logic [15:0] STK_CCR = 16'h0002;
	localparam logic [15:0] STK_ACC = 16'h0003;
	localparam logic [15:0] STK_LOW_INDEX = 16'h0004;
	localparam logic [15:0] STK_PC_HIGH = 16'h0005;
	localparam logic [15:0] STK_PC_LOW = 16'h0006;
	// Value returned for locked flash reads
	localparam logic [7:0] LOCKED_DATA = 8'h00;
	// Flash address range (start)
	localparam logic [15:0] FLASH_BASE_DEFAULT = 16'hE000;
endpackage

// file: verification/monitor_command_checker.sv
// Port checks for the monitor command block.
// Assumes one clock domain with a synchronous reset.
`timescale 1ns/1ps
module monitor_command_checker #(
	parameter int unsigned BAUD = 9600
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic srst,
	// Link and fetch
	input wire logic serial_data_pin_out,
	input wire logic serial_data_pin_oe,
	input wire logic fetch_valid,
	// Pulses and status
	input wire logic software_interrupt,
	input wire logic push_high_index,
	input wire logic pop_high_index,
	input wire logic return_from_interrupt,
	input wire logic illegal_reset,
	input wire logic unlocked,
	input wire logic monitor_active
);
	// Cycles per bit
	localparam int BIT = 40000000 / BAUD;
	// Run of driven zeros; a break is the longest legal one
	int zrun;
	always_ff @(posedge clk_sys) begin
		if (srst || serial_data_pin_out || !serial_data_pin_oe) begin
			zrun <= 0;
		end else begin
			zrun <= zrun + 1;
		end
	end
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (srst);
	reset_idle_a: assert property (disable iff (1'b0)
		srst |=> serial_data_pin_out && !serial_data_pin_oe && !unlocked)
		else $error("outputs not idle after reset");
	idle_high_a: assert property (!serial_data_pin_oe |-> serial_data_pin_out)
		else $error("released pin not high");
	break_length_a: assert property (zrun <= 10 * BIT)
		else $error("zero run longer than a break");
	entry_pair_a: assert property (software_interrupt |->
		push_high_index ##1 !software_interrupt)
		else $error("entry pulses not paired");
	run_pair_a: assert property (pop_high_index |->
		return_from_interrupt ##1 !pop_high_index)
		else $error("run pulses not paired");
	unlock_hold_a: assert property (unlocked |=> unlocked)
		else $error("unlock dropped without reset");
	unlock_source_a: assert property ($rose(unlocked) |-> monitor_active)
		else $error("unlock outside monitor");
	trap_locked_a: assert property (illegal_reset |-> !unlocked)
		else $error("trap while unlocked");
	no_trap_open_a: assert property (fetch_valid && unlocked |=> !illegal_reset)
		else $error("trap on unlocked fetch");
endmodule
bind monitor_command monitor_command_checker #(.BAUD(BAUD)) chk (
	.clk_sys(clk_sys), .srst(srst), .serial_data_pin_out(serial_data_pin_out),
	.serial_data_pin_oe(serial_data_pin_oe), .fetch_valid(fetch_valid),
	.software_interrupt(software_interrupt), .push_high_index(push_high_index),
	.pop_high_index(pop_high_index), .return_from_interrupt(return_from_interrupt),
	.illegal_reset(illegal_reset), .unlocked(unlocked), .monitor_active(monitor_active)
);

// file: verification/monitor_host.sv
// Host model driving the one-pin monitor link.
// Assumes the bench resolves the wire, with a pull-up, into line.
`timescale 1ns/1ps
module monitor_host #(
	parameter int BIT = 40
) (
	// Clock and resolved line
	input wire logic clk_sys,
	input wire logic line,
	// Host drive
	output logic host_out,
	output logic host_oe
);
	initial begin
		host_out = 1'b1;
		host_oe = 1'b0;
	end
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		// Idle a bit time so the device has released the pin
		repeat (BIT) @(posedge clk_sys);
		@(posedge clk_sys);
		#1 host_oe = 1'b1;
		for (int i = 0; i < 10; i++) begin
			host_out = f[i];
			repeat (BIT) @(posedge clk_sys);
			#1;
		end
		// Release; pull-up holds the line high
		host_oe = 1'b0;
		host_out = 1'b1;
	endtask
	// host break: ten zero bit times, then release
	task automatic send_break();
		repeat (BIT) @(posedge clk_sys);
		@(posedge clk_sys);
		#1 host_oe = 1'b1;
		host_out = 1'b0;
		repeat (10 * BIT) @(posedge clk_sys);
		#1 host_oe = 1'b0;
		host_out = 1'b1;
	endtask
	// zero stop bit marks a break
	task automatic recv_byte(output logic [8:0] r, output logic ok);
		int n;
		n = 0;
		ok = 1'b0;
		r = 9'h1FF;
		// Bounded wait for a start edge
		while (line !== 1'b0 && n < 4000) begin
			@(posedge clk_sys);
			n++;
		end
		if (n < 4000) begin
			ok = 1'b1;
			repeat (BIT / 2) @(posedge clk_sys);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT) @(posedge clk_sys);
				r[i] = line;
			end
			n = 0;
			while (line !== 1'b1 && n < 4 * BIT) begin
				@(posedge clk_sys);
				n++;
			end
		end
	endtask
endmodule

// file: verification/monitor_command_and_security_test.sv
// Bench for the monitor command block with a host model.
// Assumes the package opcodes and a 40-cycle bit.
`timescale 1ns/1ps
module monitor_command_and_security_test;
	import monitor_pkg::*;
	localparam int BIT = 40;
	logic clk_sys = 1'b0;
	logic srst, entry_select_pin, fetch_valid, mem_rd, out, oe, host_out, host_oe;
	logic software_interrupt, push_high_index, pop_high_index, return_from_interrupt;
	logic illegal_reset, unlocked, monitor_active, ok;
	logic [15:0] mem_addr, stack_pointer, fetch_addr;
	logic [7:0] mem_rdata, read_data;
	logic [7:0] sec [8];
	logic [8:0] r;
	int errors, tests_run, cycles, swis, pops, ills;
	int seed;
	wire line = oe ? out : (host_oe ? host_out : 1'b1);
	// Clock of 25 ns
	always #12.5 clk_sys = ~clk_sys;
	monitor_command #(.BAUD(1000000)) uut (
		.clk_sys(clk_sys), .srst(srst), .serial_data_pin_in(line),
		.serial_data_pin_out(out), .serial_data_pin_oe(oe),
		.entry_select_pin(entry_select_pin), .mem_rd(mem_rd), .mem_addr(mem_addr),
		.mem_rdata(mem_rdata), .stack_pointer(stack_pointer), .fetch_addr(fetch_addr),
		.fetch_valid(fetch_valid), .software_interrupt(software_interrupt),
		.push_high_index(push_high_index), .pop_high_index(pop_high_index),
		.return_from_interrupt(return_from_interrupt), .illegal_reset(illegal_reset),
		.unlocked(unlocked), .monitor_active(monitor_active), .read_data(read_data)
	);
	monitor_host #(.BIT(BIT)) host (
		.clk_sys(clk_sys), .line(line), .host_out(host_out), .host_oe(host_oe)
	);
	// Memory shows the data of the registered address within the cycle
	always @(mem_addr) mem_rdata <= #1 mem_val(mem_addr);
	// Pulse counters; hang limit
	always @(posedge clk_sys) begin
		swis += (software_interrupt === 1'b1);
		pops += (pop_high_index === 1'b1);
		ills += (illegal_reset === 1'b1);
		cycles++;
		if (cycles == 90000) begin
			errors++;
			finish_test();
		end
	end
	function automatic logic [7:0] mem_val(input logic [15:0] a);
		if (a >= SEC_FIRST && a <= SEC_LAST) return sec[a - SEC_FIRST];
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction
	// Locked flash reads give the fixed filler
	function automatic logic [7:0] want(input logic [15:0] a, input logic good);
		return (!good && a >= FLASH_BASE_DEFAULT) ? LOCKED_DATA : mem_val(a);
	endfunction
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic get(input logic [7:0] exp);
		host.recv_byte(r, ok);
		check({ok, r}, {2'b11, exp});
	endtask
	task automatic cmd(input logic [7:0] b);
		host.send_byte(b);
		get(b);
	endtask
	task automatic fetch(input logic [15:0] a, input logic good);
		cmd(OP_INDEXED_FETCH);
		get(want(a, good));
		get(want(a + 16'h0001, good));
		repeat (12 * BIT) @(posedge clk_sys);
		check({2'b00, read_data}, {2'b00, want(a + 16'h0001, good)});
	endtask
	// One opcode fetch from flash in user state
	task automatic probe_trap(input logic exp);
		ills = 0;
		#1 fetch_valid = 1'b1;
		fetch_addr = {3'b111, 13'($random(seed))};
		@(posedge clk_sys);
		#1 fetch_valid = 1'b0;
		repeat (4) @(posedge clk_sys);
		check(10'(ills), {9'h0, exp});
	endtask
	// entry select held low through reset and after
	task automatic enter(input logic good);
		int k;
		k = $unsigned($random(seed)) % 8;
		swis = 0;
		@(posedge clk_sys);
		#1 srst = 1'b1;
		entry_select_pin = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1 srst = 1'b0;
		check({9'h0, unlocked}, 10'h000);
		repeat (30) @(posedge clk_sys);
		#1 entry_select_pin = 1'b1;
		check(10'(swis), 10'h001);
		check({9'h0, monitor_active}, 10'h001);
		for (int i = 0; i < 8; i++) cmd(sec[i] ^ {7'h00, !good && i == k});
		host.recv_byte(r, ok);
		check({ok, r}, 10'h200);
		check({9'h0, unlocked}, {9'h0, good});
		repeat (12 * BIT) @(posedge clk_sys);
	endtask
	task automatic session(input logic good);
		logic [15:0] sp;
		#1 stack_pointer = 16'($random(seed));
		sp = stack_pointer + 16'h0001;
		cmd(OP_STACK_QUERY);
		get(sp[15:8]);
		get(sp[7:0]);
		repeat (12 * BIT) @(posedge clk_sys);
		fetch(16'hFFFE, good);
		fetch(16'h0000, good);
		pops = 0;
		// host leaves the stacked frame as entry left it
		cmd(OP_RUN);
		host.send_break();
		repeat (14 * BIT) @(posedge clk_sys);
		check(10'(pops), 10'h000);
		cmd(OP_RUN);
		repeat (14 * BIT) @(posedge clk_sys);
		check(10'(pops), 10'h001);
		check({9'h0, monitor_active}, 10'h000);
		probe_trap(!good);
		$display("session done, unlocked %b", good);
	endtask
	// Reset with entry-select high: user state, locked
	task automatic user_boot();
		swis = 0;
		@(posedge clk_sys);
		#1 srst = 1'b1;
		entry_select_pin = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1 srst = 1'b0;
		repeat (30) @(posedge clk_sys);
		check(10'(swis), 10'h000);
		check({9'h0, monitor_active}, 10'h000);
		check({9'h0, unlocked}, 10'h000);
		probe_trap(1'b1);
		$display("user boot done");
	endtask
	task automatic finish_test();
		$display("compared %0d, mismatched %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		seed = 32'h2FFA30EC;
		srst = 1'b1;
		entry_select_pin = 1'b0;
		fetch_valid = 1'b0;
		fetch_addr = 16'h0000;
		stack_pointer = 16'h00FF;
		for (int i = 0; i < 8; i++) sec[i] = 8'($random(seed));
		enter(1'b0);
		session(1'b0);
		enter(1'b1);
		session(1'b1);
		// erased flash keyed with all ones
		for (int i = 0; i < 8; i++) sec[i] = 8'hFF;
		enter(1'b1);
		user_boot();
		finish_test();
	end
endmodule
